// ---- rtl/rlc_pkg.sv ----
/*
 * Constants for the read latency and drive strength configuration block:
 * command opcodes, register field positions, reset values, default dummy
 * counts and the command-decoder state type.
 * Assumes a single system clock domain in the block that imports nothing
 * and names everything as rlc_pkg::name.
 */
package rlc_pkg;

  // opcodes of the read commands whose dummy count this block sets
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_FAST_READ_DTR = 8'h0D;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_DTR = 8'hBD;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_DTR = 8'hED;

  // opcodes of the configuration writes
  localparam logic [7:0] OP_SET_EXT_NV = 8'h85;
  localparam logic [7:0] OP_SET_EXT_V = 8'h83;
  localparam logic [7:0] OP_SET_READ_NV = 8'h65;
  localparam logic [7:0] OP_SET_READ_V = 8'hC0;
  localparam logic [7:0] OP_SET_READ_V_ALT = 8'h63;

  // default dummy counts when the dummy field is zero
  localparam logic [3:0] DUMMY_SPI_FAST = 4'h8;
  localparam logic [3:0] DUMMY_QPI_FAST = 4'h6;
  localparam logic [3:0] DUMMY_OUTPUT = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
  localparam logic [3:0] DUMMY_FIELD_OFF = 4'h0;

  // read configuration register fields
  localparam int DUMMY_LSB = 3;
  localparam int DUMMY_MSB = 6;
  localparam logic [7:0] READ_REG_RESET = 8'h00;

  // extended read configuration register fields
  localparam int DRIVE_LSB = 5;
  localparam int DRIVE_MSB = 7;
  localparam logic [7:0] EXT_RSVD_MASK = 8'h1F;
  localparam logic [7:0] EXT_REG_RESET = 8'hFF;
  localparam logic [2:0] DRIVE_DEFAULT = 3'h7;
  localparam logic [2:0] DRIVE_RSVD_LO = 3'h0;
  localparam logic [2:0] DRIVE_RSVD_HI = 3'h4;

  // serial shift: bits per link clock and bits per byte
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_QUAD = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_OPCODE,
    ST_DATA,
    ST_SKIP
  } rlc_state_t;

endpackage

// ---- rtl/rlc_config.sv ----
/*
 * Read latency and output drive configuration inside a serial flash.
 * Decodes the opcode of each frame on the serial link, answers read
 * commands with their dummy count, counts out the dummy clocks, and takes
 * the configuration writes into volatile and non-volatile copies.
 * Assumes sck, cs_n and io_in come straight from pins (asynchronous to
 * clk_sys, sck well below a quarter of clk_sys); qpi_mode and dummy_start
 * come from logic on clk_sys. The address and data datapath lies outside.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - zero field picks per-command default dummy counts
// - id, discovery, info-row reads follow fast read
// - dual io double-rate read refused in QPI
// - drive bits 7..5, bits 4..0 read one
// - drive code 111 default, 000/100 reserved
// - 85h writes persistent copy, 83h volatile
// - power-up copies persistent into volatile copies
// - read config bits 6..3 hold dummy count
module rlc_config #(
  parameter logic [7:0] OP_READ_UNIQUE_ID = 8'h4B,
  parameter logic [7:0] OP_READ_DISCOVERY = 8'h5A,
  parameter logic [7:0] OP_READ_INFO_ROW = 8'h68
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  // interface mode from the command logic
  input wire logic qpi_mode,
  // read datapath handshake
  input wire logic dummy_start,
  output logic read_start,
  output logic [7:0] read_opcode,
  output logic [3:0] read_dummy,
  output logic dummy_busy,
  output logic data_phase,
  output logic cmd_refused,
  // configuration state
  output logic config_ready,
  output logic [7:0] read_reg,
  output logic [7:0] ext_reg,
  output logic [2:0] drive_select,
  output logic drive_reserved
);

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic cs_s1;
    logic cs_s2;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    rlc_pkg::rlc_state_t state;
    logic [7:0] shift;
    logic [3:0] bits;
    logic [7:0] op;
    logic [7:0] nv_read;
    logic [7:0] nv_ext;
    logic [7:0] vol_read;
    logic [7:0] vol_ext;
    logic read_start;
    logic [7:0] read_opcode;
    logic [3:0] read_dummy;
    logic read_qpi;
    logic refused;
    logic busy;
    logic [3:0] cnt;
    logic data_phase;
  } rlc_regs_t;

  localparam rlc_regs_t RESET_STATE = '{
    sck_s1: 1'b0, sck_s2: 1'b0, sck_d: 1'b0,
    cs_s1: 1'b1, cs_s2: 1'b1, io_s1: 4'h0, io_s2: 4'h0,
    state: rlc_pkg::ST_LOAD, shift: 8'h00, bits: 4'h0, op: 8'h00,
    nv_read: rlc_pkg::READ_REG_RESET, nv_ext: rlc_pkg::EXT_REG_RESET,
    vol_read: rlc_pkg::READ_REG_RESET, vol_ext: rlc_pkg::EXT_REG_RESET,
    read_start: 1'b0, read_opcode: 8'h00, read_dummy: 4'h0,
    read_qpi: 1'b0, refused: 1'b0, busy: 1'b0, cnt: 4'h0,
    data_phase: 1'b0
  };

  rlc_regs_t q;
  rlc_regs_t next_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // dummy count for a read opcode; zero when the opcode is not a read
  function automatic logic [3:0] dummy_for(input logic [7:0] op,
                                           input logic qpi,
                                           input logic [3:0] field);
    logic [3:0] dflt;
    dflt = 4'h0;
    if (op == rlc_pkg::OP_FAST_READ || op == rlc_pkg::OP_FAST_READ_DTR ||
        op == OP_READ_UNIQUE_ID || op == OP_READ_DISCOVERY ||
        op == OP_READ_INFO_ROW) begin
      dflt = qpi ? rlc_pkg::DUMMY_QPI_FAST : rlc_pkg::DUMMY_SPI_FAST;
    end else if (op == rlc_pkg::OP_DUAL_OUT ||
                 op == rlc_pkg::OP_QUAD_OUT) begin
      dflt = rlc_pkg::DUMMY_OUTPUT;
    end else if (op == rlc_pkg::OP_DUAL_IO ||
                 op == rlc_pkg::OP_DUAL_IO_DTR) begin
      dflt = rlc_pkg::DUMMY_DUAL_IO;
    end else if (op == rlc_pkg::OP_QUAD_IO ||
                 op == rlc_pkg::OP_QUAD_IO_DTR) begin
      dflt = rlc_pkg::DUMMY_QUAD_IO;
    end
    // a programmed field overrides every default
    if (dflt != 4'h0 && field != rlc_pkg::DUMMY_FIELD_OFF) begin
      dflt = field;
    end
    return dflt;
  endfunction
  logic rise;
  logic [7:0] shifted;
  logic [3:0] bits_inc;
  logic [3:0] field;
  logic [3:0] op_dummy;

  // link sampling helpers; only the second sync stage is looked at
  assign rise = q.sck_s2 & ~q.sck_d;
  assign shifted = qpi_mode ? {q.shift[3:0], q.io_s2}
                            : {q.shift[6:0], q.io_s2[0]};
  assign bits_inc = q.bits +
    (qpi_mode ? rlc_pkg::STEP_QUAD : rlc_pkg::STEP_SINGLE);
  assign field = q.vol_read[rlc_pkg::DUMMY_MSB:rlc_pkg::DUMMY_LSB];
  assign op_dummy = dummy_for(shifted, qpi_mode, field);
  // next-state logic for synchronisers, decoder, registers and counter
  always_comb begin
    next_q = q;
    next_q.sck_s1 = sck;
    next_q.sck_s2 = q.sck_s1;
    next_q.sck_d = q.sck_s2;
    next_q.cs_s1 = cs_n;
    next_q.cs_s2 = q.cs_s1;
    next_q.io_s1 = io_in;
    next_q.io_s2 = q.io_s1;
    next_q.read_start = 1'b0;
    next_q.refused = 1'b0;
    next_q.data_phase = 1'b0;
    case (q.state)
      rlc_pkg::ST_LOAD: begin
        // persistent copies seed the working copies before any command
        next_q.vol_read = q.nv_read;
        next_q.vol_ext = q.nv_ext | rlc_pkg::EXT_RSVD_MASK;
        next_q.state = rlc_pkg::ST_SKIP;
      end
      rlc_pkg::ST_OPCODE: begin
        if (q.cs_s2) begin
          next_q.bits = 4'h0;
        end else if (rise) begin
          next_q.shift = shifted;
          next_q.bits = bits_inc;
          if (bits_inc == rlc_pkg::BYTE_BITS) begin
            next_q.bits = 4'h0;
            next_q.op = shifted;
            next_q.state = rlc_pkg::ST_SKIP;
            if (shifted == rlc_pkg::OP_SET_EXT_NV ||
                shifted == rlc_pkg::OP_SET_EXT_V ||
                shifted == rlc_pkg::OP_SET_READ_NV ||
                shifted == rlc_pkg::OP_SET_READ_V ||
                shifted == rlc_pkg::OP_SET_READ_V_ALT) begin
              next_q.state = rlc_pkg::ST_DATA;
            end else if (shifted == rlc_pkg::OP_DUAL_IO_DTR && qpi_mode) begin
              next_q.refused = 1'b1;
            end else if (op_dummy != 4'h0) begin
              next_q.read_start = 1'b1;
              next_q.read_opcode = shifted;
              next_q.read_dummy = op_dummy;
              next_q.read_qpi = qpi_mode;
            end
          end
        end
      end
      rlc_pkg::ST_DATA: begin
        // a byte cut short by deselect is dropped, nothing is written
        if (q.cs_s2) begin
          next_q.bits = 4'h0;
          next_q.state = rlc_pkg::ST_OPCODE;
        end else if (rise) begin
          next_q.shift = shifted;
          next_q.bits = bits_inc;
          if (bits_inc == rlc_pkg::BYTE_BITS) begin
            next_q.bits = 4'h0;
            next_q.state = rlc_pkg::ST_SKIP;
            case (q.op)
              rlc_pkg::OP_SET_EXT_NV:
                next_q.nv_ext = shifted | rlc_pkg::EXT_RSVD_MASK;
              rlc_pkg::OP_SET_EXT_V:
                next_q.vol_ext = shifted | rlc_pkg::EXT_RSVD_MASK;
              rlc_pkg::OP_SET_READ_NV:
                next_q.nv_read = shifted;
              default:
                next_q.vol_read = shifted;
            endcase
          end
        end
      end
      rlc_pkg::ST_SKIP: begin
        // rest of the frame belongs to the datapath; wait for deselect
        if (q.cs_s2) begin
          next_q.bits = 4'h0;
          next_q.state = rlc_pkg::ST_OPCODE;
        end
      end
      default: begin
        next_q.state = rlc_pkg::ST_LOAD;
      end
    endcase
    // dummy clock counter, one count per link clock rising edge
    if (q.cs_s2) begin
      next_q.busy = 1'b0;
    end else if (dummy_start && !q.busy) begin
      next_q.busy = 1'b1;
      next_q.cnt = q.read_dummy;
    end else if (q.busy && rise) begin
      if (q.cnt == 4'h1) begin
        next_q.busy = 1'b0;
        next_q.data_phase = 1'b1;
      end else begin
        next_q.cnt = q.cnt - 4'h1;
      end
    end
  end

  // the whole block state in one register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops, except config_ready and drive_reserved, which are decoded from them
  assign read_start = q.read_start;
  assign read_opcode = q.read_opcode;
  assign read_dummy = q.read_dummy;
  assign dummy_busy = q.busy;
  assign data_phase = q.data_phase;
  assign cmd_refused = q.refused;
  assign config_ready = (q.state != rlc_pkg::ST_LOAD);
  assign read_reg = q.vol_read;
  assign ext_reg = q.vol_ext;
  assign drive_select = q.vol_ext[rlc_pkg::DRIVE_MSB:rlc_pkg::DRIVE_LSB];
  assign drive_reserved = (drive_select == rlc_pkg::DRIVE_RSVD_LO) ||
                          (drive_select == rlc_pkg::DRIVE_RSVD_HI);

  chk_fast_default: assert property (
    q.read_start && q.read_opcode == rlc_pkg::OP_FAST_READ &&
    q.vol_read[6:3] == 4'h0 |-> q.read_dummy == (q.read_qpi ? 4'h6 : 4'h8))
    else $error("fast read default dummy count wrong");
  chk_dual_io_default: assert property (
    q.read_start && q.read_opcode == rlc_pkg::OP_DUAL_IO &&
    q.vol_read[6:3] == 4'h0 |-> q.read_dummy == 4'h4)
    else $error("dual io default dummy count wrong");
  chk_uid_follows_fast: assert property (
    q.read_start && q.read_opcode == OP_READ_UNIQUE_ID |-> q.read_dummy ==
    (q.vol_read[6:3] != 4'h0 ? q.vol_read[6:3] : q.read_qpi ? 4'h6 : 4'h8))
    else $error("unique id read dummy differs from fast read");
  chk_qpi_dual_dtr: assert property (
    q.read_start |->
    !(q.read_opcode == rlc_pkg::OP_DUAL_IO_DTR && q.read_qpi))
    else $error("dual io double-rate read accepted in qpi");
  chk_rsvd_ones: assert property (
    config_ready |-> ext_reg[4:0] == 5'h1F ##1 ext_reg[4:0] == 5'h1F)
    else $error("reserved extended bits not one");
  chk_drive_load: assert property (
    q.state == rlc_pkg::ST_LOAD |=>
    drive_select == $past(q.nv_ext[7:5]) && config_ready)
    else $error("drive select not loaded from persistent copy");
  chk_volatile_write: assert property (
    q.state == rlc_pkg::ST_DATA && q.op == rlc_pkg::OP_SET_EXT_V
    ##1 q.state == rlc_pkg::ST_SKIP |-> $stable(q.nv_ext))
    else $error("volatile write changed persistent copy");
  chk_persist_write: assert property (
    q.state == rlc_pkg::ST_DATA && q.op == rlc_pkg::OP_SET_EXT_NV
    ##1 q.state == rlc_pkg::ST_SKIP |-> $stable(q.vol_ext))
    else $error("persistent write changed working copy");
  chk_power_load: assert property (
    $rose(config_ready) |->
    read_reg == $past(q.nv_read) && !$past(q.read_start))
    else $error("read config not loaded at power-up");
  chk_field_used: assert property (
    q.read_start && q.vol_read[6:3] != 4'h0 |->
    q.read_dummy == q.vol_read[6:3])
    else $error("programmed dummy field ignored");
  chk_dummy_count: assert property (
    $rose(q.busy) |-> q.cnt == $past(q.read_dummy) && !q.data_phase)
    else $error("dummy counter loaded wrong");
  chk_dummy_end: assert property (
    q.data_phase |-> $past(q.busy) && $past(q.cnt) == 4'h1 && !q.busy)
    else $error("data phase before last dummy clock");
  cov_read_start: cover property (q.read_start && q.vol_read[6:3] != 4'h0);
  cov_refused: cover property (q.refused);
  cov_ext_write: cover property (
    q.state == rlc_pkg::ST_DATA ##1 q.state == rlc_pkg::ST_SKIP);
  cov_dummy_done: cover property (q.data_phase);

endmodule

// ---- test/rlc_host.sv ----
/*
 * Behavioural host controller for the serial link of the read latency
 * and drive configuration block: frames, opcode and data shifting, and
 * dummy clocks. Assumes a 100 MHz clk_sys; everything changes by
 * non-blocking assignment just after a rising edge of it.
 */
`timescale 1ns/1ps

module rlc_host (
  // system clock used for pacing
  input wire logic clk_sys,
  // link pins toward the device
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_in
);
  // idle link: clock parked low, deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'hA;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic open_frame();
    @(posedge clk_sys);
    cs_n <= 1'b0;
    wait_clk(3);
  endtask

  // 6 cycles high, 6 low: both phases stay above 3 clk_sys cycles
  task automatic pulse();
    sck <= 1'b1;
    wait_clk(6);
    sck <= 1'b0;
    wait_clk(6);
  endtask

  // msb first; quad sends the high nibble first
  task automatic shift(input logic [7:0] b, input logic quad);
    int i;
    for (i = 0; i < 8; i += (quad ? 4 : 1)) begin
      if (quad)
        io_in <= b[7 - i -: 4];
      else
        io_in[0] <= b[7 - i];
      wait_clk(3);
      pulse();
    end
  endtask

  // data lines float during dummies, so they change every clock
  task automatic dummies(input int n);
    repeat (n) begin
      io_in <= ~io_in;
      wait_clk(1);
      pulse();
    end
  endtask

  // released lines show the inverse of their last value
  task automatic close_frame();
    cs_n <= 1'b1;
    io_in <= ~io_in;
    wait_clk(5);
  endtask
endmodule

// ---- test/read_latency_and_drive_config_test.sv ----
/*
 * Self-checking bench for the read latency and drive configuration block.
 * Assumes the host model in rlc_host.sv and the design in rlc_config.sv;
 * register writes travel only over the serial link.
 */
`timescale 1ns/1ps

module read_latency_and_drive_config_test;
  logic clk_sys;
  logic rstn = 1'b0;
  logic qpi_mode = 1'b0;
  logic dummy_start = 1'b0;
  logic sck, cs_n, read_start, dummy_busy, data_phase, cmd_refused;
  logic [3:0] io_in, read_dummy;
  logic [7:0] read_opcode, read_reg, ext_reg;
  logic [2:0] drive_select;
  logic config_ready, drive_reserved;
  int bad_count = 0;
  int tests_run = 0;
  int n_start = 0;
  int n_ref = 0;
  int n_data = 0;

  rlc_host host (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .io_in(io_in));

  // id read opcodes keep their defaults
  rlc_config dut (
    .clk_sys(clk_sys), .rstn(rstn), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .qpi_mode(qpi_mode), .dummy_start(dummy_start),
    .read_start(read_start), .read_opcode(read_opcode),
    .read_dummy(read_dummy), .dummy_busy(dummy_busy),
    .data_phase(data_phase), .cmd_refused(cmd_refused),
    .config_ready(config_ready), .read_reg(read_reg), .ext_reg(ext_reg),
    .drive_select(drive_select), .drive_reserved(drive_reserved));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // pulses are counted so a test never has to hit the exact cycle
  always @(posedge clk_sys) begin
    if (read_start === 1'b1) n_start++;
    if (cmd_refused === 1'b1) n_ref++;
    if (data_phase === 1'b1) n_data++;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    host.wait_clk(2);
    rstn <= 1'b1;
    host.wait_clk(6);
  endtask

  // opcode frame left open; start pulse, count and opcode judged
  task automatic read_cmd(input logic [7:0] op, input logic [3:0] exp);
    int s;
    s = n_start;
    host.open_frame();
    host.shift(op, qpi_mode);
    host.wait_clk(8);
    check("read_start", 8'(n_start - s), 8'h01);
    check("read_dummy", {4'h0, read_dummy}, {4'h0, exp});
    check("read_opcode", read_opcode, op);
  endtask

  task automatic write_cmd(input logic [7:0] op, input logic [7:0] b);
    host.open_frame();
    host.shift(op, qpi_mode);
    host.shift(b, qpi_mode);
    host.wait_clk(8);
    host.close_frame();
  endtask

  task automatic test_reset_values();
    check("config_ready", {7'h0, config_ready}, 8'h01);
    check("read_reg", read_reg, 8'h00);
    check("ext_reg", ext_reg, 8'hFF);
    check("drive_select", {5'h0, drive_select}, 8'h07);
    $display("done reset values");
  endtask

  task automatic test_default_dummies();
    logic [7:0] ops [11] = '{8'h0B, 8'h0D, 8'h3B, 8'hBB, 8'hBD, 8'h6B,
                             8'hEB, 8'hED, 8'h4B, 8'h5A, 8'h68};
    logic [3:0] spi [11] = '{4'h8, 4'h8, 4'h8, 4'h4, 4'h4, 4'h8,
                             4'h6, 4'h6, 4'h8, 4'h8, 4'h8};
    int i;
    for (i = 0; i < 11; i++) begin
      read_cmd(ops[i], spi[i]);
      host.close_frame();
    end
    qpi_mode <= 1'b1;
    for (i = 0; i < 11; i++) begin
      if (spi[i] != 4'h6 && ops[i] != 8'h0B && ops[i] != 8'h0D
          && ops[i][7:4] != 4'h4 && ops[i][7:4] != 4'h5
          && ops[i] != 8'h68)
        continue;
      read_cmd(ops[i], 4'h6);
      host.close_frame();
    end
    $display("done default dummies");
  endtask

  task automatic test_qpi_refusal();
    int s, r;
    s = n_start;
    r = n_ref;
    host.open_frame();
    host.shift(8'hBD, 1'b1);
    host.wait_clk(8);
    host.close_frame();
    check("refused", 8'(n_ref - r), 8'h01);
    check("no_start", 8'(n_start - s), 8'h00);
    qpi_mode <= 1'b0;
    $display("done qpi refusal");
  endtask

  task automatic test_drive_codes();
    int c;
    for (c = 0; c < 8; c++) begin
      write_cmd(8'h83, {c[2:0], 5'h00});
      check("ext_reg", ext_reg, {c[2:0], 5'h1F});
      check("drive_select", {5'h0, drive_select}, 8'(c));
      check("drive_reserved", {7'h0, drive_reserved},
            (c == 0 || c == 4) ? 8'h01 : 8'h00);
    end
    write_cmd(8'h85, 8'h20);
    write_cmd(8'h65, 8'h28);
    check("ext_before_reset", ext_reg, 8'hFF);
    check("read_before_reset", read_reg, 8'h00);
    do_reset();
    // persistent copies are flops that reset loads with their reset values, so defaults come back
    check("ext_loaded", ext_reg, 8'hFF);
    check("read_loaded", read_reg, 8'h00);
    $display("done drive codes");
  endtask

  // field 1 and field 15 are the boundaries of the counted range
  task automatic test_dummy_count();
    logic [3:0] f [2] = '{4'h1, 4'hF};
    logic [7:0] op [2] = '{8'h0B, 8'h4B};
    int i, d;
    for (i = 0; i < 2; i++) begin
      write_cmd(i == 0 ? 8'hC0 : 8'h63, {1'b0, f[i], 3'h0});
      check("read_reg", read_reg, {1'b0, f[i], 3'h0});
      read_cmd(op[i], f[i]);
      d = n_data;
      @(posedge clk_sys);
      dummy_start <= 1'b1;
      @(posedge clk_sys);
      dummy_start <= 1'b0;
      host.wait_clk(2);
      host.dummies(f[i] - 1);
      check("busy", {7'h0, dummy_busy}, 8'h01);
      check("early_data", 8'(n_data - d), 8'h00);
      host.dummies(1);
      check("data_phase", 8'(n_data - d), 8'h01);
      check("busy_end", {7'h0, dummy_busy}, 8'h00);
      host.close_frame();
    end
    $display("done dummy count");
  endtask

  // bound well above the roughly 5500 cycles the tests need
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    do_reset();
    test_reset_values();
    test_default_dummies();
    test_qpi_refusal();
    test_drive_codes();
    test_dummy_count();
    end_sim();
  end
endmodule
